/* File: bsms_defines.svh */
// Constants for the boot strap and memory select block
// What this block does
// RULE1: Processor reset asserts on supply up, down, brownout, and push-button press.
// RULE2: Every reset event holds the active-low processor reset at least 200 ms.
// RULE3: Default straps give a 33.25 MHz input times four, about 133 MHz core.
// RULE4: Default PLL range straps select the 120 to 180 MHz band.
// RULE5: Interrupt lines rest low; requests are low-to-high transitions.
// RULE6: Strap levels on host address pins 13..1 stand while processor is in reset.
// RULE7: Strap on pin 1 picks the memory map, external or internal boot.
// RULE8: Straps on pins 3..2 give the space 0 memory type.
// RULE9: Straps on pins 5..4 give the space 2 memory type.
// RULE10: Straps on pins 7..6 give the space 1 asynchronous memory width.
// RULE11: Straps on pins 10..8 give the boot transfer word count.
// RULE12: Selector open routes switch bank, closed routes host levels, onto strap pins.
// RULE13: Decoder holds space 0 and space 2 type codes sampled during reset.
// RULE14: Held types plus active space select enable at most one memory; SDRAM and reserved type codes enable none.
// RULE15: Three separate active-low enables: burst SRAM, async SRAM, ROM.
// RULE16: Type code 11 async, 10 burst SRAM, 01 reserved, 00 SDRAM.
// RULE17: Default map: burst SRAM space 0, ROM space 1, async SRAM space 2.
// RULE18: Type latch captures at processor reset release, holds through the next reset until its release.
// RULE19: No space select active keeps all three enables high.
`ifndef BSMS_DEFINES_SVH
`define BSMS_DEFINES_SVH

// Strap pin field positions
`define BSMS_STRAP_MSB 13
`define BSMS_STRAP_LSB 1
`define BSMS_MAP_BIT 1
`define BSMS_S0_TYPE_LSB 2
`define BSMS_S2_TYPE_LSB 4
`define BSMS_S1_WIDTH_LSB 6
`define BSMS_BOOT_LSB 8
`define BSMS_BOOT_W 3

// Register byte offsets
`define BSMS_OFS_CTRL 4'h0
`define BSMS_OFS_SAMPLED 4'h4
`define BSMS_OFS_STATUS 4'h8
`define BSMS_OFS_PINS 4'hc

// Control register fields
`define BSMS_CTRL_SOFT_RST 0
`define BSMS_CTRL_MULT_LSB 1
`define BSMS_CTRL_RANGE_LSB 3
`define BSMS_CTRL_IRQ_LSB 6

// Reset values
`define BSMS_MULT_RST 2'h3
`define BSMS_RANGE_RST 3'h2
`define BSMS_IRQ_RST 5'h00

// Timing
`define BSMS_CLK_KHZ 125000
`define BSMS_RST_HOLD_MS 200
`define BSMS_BOARD_CLK_KHZ 33250
`define BSMS_CORE_CLK_KHZ 133000

`endif

/* File: bsms_pkg.sv */
// Types for the boot strap and memory select block
package bsms_pkg;
    typedef enum logic [1:0] {
        BSMS_MEM_SDRAM = 2'h0,
        BSMS_MEM_RSVD = 2'h1,
        BSMS_MEM_BURST = 2'h2,
        BSMS_MEM_ASYNC = 2'h3
    } bsms_mem_type_t;
    typedef logic [12:0] bsms_strap_t;
endpackage

/* File: bsms_reset_stretch.sv */
// Reset stretcher for the processor reset line
`include "bsms_defines.svh"
module bsms_reset_stretch #(
    parameter int unsigned HOLD_CYCLES = `BSMS_RST_HOLD_MS * `BSMS_CLK_KHZ
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Reset cause, high while any cause stands
    input wire logic i_event,
    // Stretched reset
    output logic o_reset_n
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    generate
        if (HOLD_CYCLES < 1) begin : g_bad
            $error("HOLD_CYCLES must be at least one");
        end
    endgenerate

    logic [CW-1:0] count_ff;

    // Reload while the cause stands, so the hold runs from its end
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || i_event) begin
            count_ff <= CW'(HOLD_CYCLES); // [RULE2]
        end else if (count_ff != '0) begin
            count_ff <= count_ff - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || i_event) begin
            o_reset_n <= 1'b0; // [RULE1]
        end else begin
            o_reset_n <= (count_ff == '0); // [RULE2]
        end
    end

    // Helper: cycles the line has been low
    logic [31:0] low_run_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || o_reset_n) begin
            low_run_ff <= 32'h0;
        end else if (low_run_ff != 32'hffffffff) begin
            low_run_ff <= low_run_ff + 32'h1;
        end
    end

    a_event_asserts: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE1]
        i_event |=> !o_reset_n)
        else $error("reset cause did not assert processor reset");
    a_hold_minimum: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE2]
        $rose(o_reset_n) |-> $past(low_run_ff) >= HOLD_CYCLES)
        else $error("processor reset released too early");
    c_release: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(o_reset_n));
endmodule

/* File: bsms_top.sv */
// Strap source mux, reset generator, PLL and interrupt straps, memory select
`include "bsms_defines.svh"
module bsms_top #(
    parameter int unsigned RST_HOLD_CYCLES = `BSMS_RST_HOLD_MS * `BSMS_CLK_KHZ
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Reset causes
    input wire logic i_supply_ok,
    input wire logic i_reset_button_n,
    // Processor reset
    output logic o_proc_reset_n,
    // Strap sources
    input wire logic i_config_source_select,
    input wire bsms_pkg::bsms_strap_t i_switch_straps,
    input wire bsms_pkg::bsms_strap_t i_host_strap_levels,
    // Dual-purpose strap pins 13..1
    input wire bsms_pkg::bsms_strap_t i_host_address_strap_pins,
    output bsms_pkg::bsms_strap_t o_host_address_strap_pins,
    output bsms_pkg::bsms_strap_t o_host_address_strap_pins_oe,
    // Clock straps
    output logic o_pll_multiplier_bit0,
    output logic o_pll_multiplier_bit1,
    output logic o_pll_range_bit1,
    output logic o_pll_range_bit2,
    output logic o_pll_range_bit3,
    // Interrupt lines: nmi, ext_irq_a..ext_irq_d
    output logic [4:0] o_ext_irq,
    // Processor space selects
    input wire logic i_space0_select_n,
    input wire logic i_space1_select_n,
    input wire logic i_space2_select_n,
    // Memory enables
    output logic o_burst_sram_enable_n,
    output logic o_async_sram_enable_n,
    output logic o_rom_enable_n,
    // Avalon-MM slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);
    import bsms_pkg::*;

    localparam int SW = 3 * 13 + 6;

    // Enables as active-high one-hot {rom, async, burst}
    function automatic logic [2:0] type_enable(input logic [1:0] code);
        case (bsms_mem_type_t'(code))
            BSMS_MEM_ASYNC: type_enable = 3'h2; // [RULE16]
            BSMS_MEM_BURST: type_enable = 3'h1; // [RULE16]
            BSMS_MEM_SDRAM: type_enable = 3'h0; // No SDRAM fitted
            BSMS_MEM_RSVD: type_enable = 3'h0;
            default: type_enable = 3'h0;
        endcase
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [3:0] mult_factor(input logic [1:0] m);
        case (m)
            2'h0: mult_factor = 4'h1;
            2'h2: mult_factor = 4'h2;
            2'h3: mult_factor = 4'h4;
            default: mult_factor = 4'h0; // Reserved code
        endcase
    endfunction

    // Pin synchroniser; first stage feeds only the second
    logic [SW-1:0] meta_ff;
    logic [SW-1:0] sync_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            meta_ff <= {SW{1'b0}};
            sync_ff <= {SW{1'b0}};
        end else begin
            meta_ff <= {i_host_strap_levels, i_switch_straps, i_host_address_strap_pins,
                        i_config_source_select, i_reset_button_n, i_supply_ok,
                        i_space0_select_n, i_space1_select_n, i_space2_select_n};
            sync_ff <= meta_ff;
        end
    end

    bsms_strap_t host_s;
    bsms_strap_t sw_s;
    bsms_strap_t pins_s;
    logic src_host_s;
    logic button_n_s;
    logic supply_ok_s;
    logic s0_n_s;
    logic s1_n_s;
    logic s2_n_s;
    assign {host_s, sw_s, pins_s, src_host_s, button_n_s, supply_ok_s,
            s0_n_s, s1_n_s, s2_n_s} = sync_ff;

    // Straps seen by the processor
    bsms_strap_t strap_mux;
    assign strap_mux = src_host_s ? host_s : sw_s; // [RULE12]

    // Register file state
    logic soft_rst_ff;
    logic [1:0] mult_ff;
    logic [2:0] range_ff;
    logic [4:0] irq_ff;
    logic ack_ff;
    logic wr_take;
    assign wr_take = i_avs_write && ack_ff;

    // Reset generation; synchroniser resets to zero so a cause stands at start
    logic rst_cause;
    assign rst_cause = !supply_ok_s || !button_n_s || soft_rst_ff; // [RULE1]

    bsms_reset_stretch #(
        .HOLD_CYCLES(RST_HOLD_CYCLES)
    ) u_stretch (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_event(rst_cause),
        .o_reset_n(o_proc_reset_n)
    );

    // Drive straps only while the processor samples them
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_host_address_strap_pins <= 13'h0000;
            o_host_address_strap_pins_oe <= 13'h0000;
        end else begin
            o_host_address_strap_pins <= strap_mux; // [RULE6]
            o_host_address_strap_pins_oe <= {13{!o_proc_reset_n}}; // [RULE6]
        end
    end

    // Captured at reset release: map, types, width, boot count
    bsms_strap_t latched_ff;
    logic src_latched_ff;
    logic proc_rst_n_d_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            proc_rst_n_d_ff <= 1'b0;
        end else begin
            proc_rst_n_d_ff <= o_proc_reset_n;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            latched_ff <= 13'h0000;
            src_latched_ff <= 1'b0;
        end else if (o_proc_reset_n && !proc_rst_n_d_ff) begin
            latched_ff <= o_host_address_strap_pins; // [RULE13] [RULE18]
            src_latched_ff <= src_host_s;
        end
    end

    logic [1:0] space0_memory_type;
    logic [1:0] space2_memory_type;
    logic [1:0] space1_async_width;
    logic [2:0] boot_word_count;
    logic mem_map_sel;
    assign mem_map_sel = latched_ff[`BSMS_MAP_BIT - 1]; // [RULE7]
    assign space0_memory_type = latched_ff[`BSMS_S0_TYPE_LSB - 1 +: 2]; // [RULE8]
    assign space2_memory_type = latched_ff[`BSMS_S2_TYPE_LSB - 1 +: 2]; // [RULE9]
    assign space1_async_width = latched_ff[`BSMS_S1_WIDTH_LSB - 1 +: 2]; // [RULE10]
    assign boot_word_count = latched_ff[`BSMS_BOOT_LSB - 1 +: `BSMS_BOOT_W]; // [RULE11]

    // Memory select; fixed priority keeps at most one enable even if selects overlap
    logic [2:0] nxt_en;
    logic [2:0] en_ff;
    always_comb begin
        if (!s0_n_s) begin
            nxt_en = type_enable(space0_memory_type); // [RULE14] [RULE17]
        end else if (!s1_n_s) begin
            nxt_en = 3'h4; // [RULE17]
        end else if (!s2_n_s) begin
            nxt_en = type_enable(space2_memory_type); // [RULE14] [RULE17]
        end else begin
            nxt_en = 3'h0; // [RULE19]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !o_proc_reset_n) begin
            en_ff <= 3'h0;
        end else begin
            en_ff <= nxt_en;
        end
    end

    assign o_rom_enable_n = !en_ff[2]; // [RULE15]
    assign o_async_sram_enable_n = !en_ff[1]; // [RULE15]
    assign o_burst_sram_enable_n = !en_ff[0]; // [RULE15]

    // Bus handshake: one wait state on every access
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (i_avs_read || i_avs_write) && !ack_ff;
        end
    end
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;

    // Control register
    logic [31:0] ctrl_val;
    logic [31:0] ctrl_new;
    assign ctrl_val = {21'h0, irq_ff, range_ff, mult_ff, 1'b0};
    assign ctrl_new = (ctrl_val & ~lane_mask(i_avs_byteenable)) |
                      (i_avs_writedata & lane_mask(i_avs_byteenable));

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            mult_ff <= `BSMS_MULT_RST; // [RULE3]
            range_ff <= `BSMS_RANGE_RST; // [RULE4]
            irq_ff <= `BSMS_IRQ_RST; // [RULE5]
        end else if (wr_take && i_avs_address == `BSMS_OFS_CTRL) begin
            mult_ff <= ctrl_new[`BSMS_CTRL_MULT_LSB +: 2];
            range_ff <= ctrl_new[`BSMS_CTRL_RANGE_LSB +: 3];
            irq_ff <= ctrl_new[`BSMS_CTRL_IRQ_LSB +: 5];
        end
    end

    // Soft reset is a one-cycle cause; the stretcher gives it full length
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= wr_take && i_avs_address == `BSMS_OFS_CTRL &&
                           ctrl_new[`BSMS_CTRL_SOFT_RST];
        end
    end

    assign o_pll_multiplier_bit0 = mult_ff[0];
    assign o_pll_multiplier_bit1 = mult_ff[1];
    assign o_pll_range_bit1 = range_ff[0];
    assign o_pll_range_bit2 = range_ff[1];
    assign o_pll_range_bit3 = range_ff[2];
    assign o_ext_irq = irq_ff;

    // Read data, loaded in the wait cycle so it stands at the ack edge
    logic [31:0] nxt_rdata;
    always_comb begin
        case (i_avs_address)
            `BSMS_OFS_CTRL: nxt_rdata = ctrl_val;
            `BSMS_OFS_SAMPLED: nxt_rdata = {18'h0, latched_ff[12:10], boot_word_count,
                                            space1_async_width, space2_memory_type,
                                            space0_memory_type, mem_map_sel,
                                            src_latched_ff};
            `BSMS_OFS_STATUS: nxt_rdata = {20'h0, mult_factor(mult_ff), en_ff,
                                           src_host_s, 1'b0,
                                           rst_cause, o_proc_reset_n, 1'b0};
            `BSMS_OFS_PINS: nxt_rdata = {18'h0, pins_s, 1'b0};
            default: nxt_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_avs_readdata <= 32'h0;
        end else if (i_avs_read && !ack_ff) begin
            o_avs_readdata <= nxt_rdata;
        end
    end

    // Checks
    a_pll_mult_default: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE3]
        $past(!i_rst_b) |-> {o_pll_multiplier_bit1, o_pll_multiplier_bit0} == 2'h3)
        else $error("PLL multiplier not times four after reset");
    a_pll_range_default: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE4]
        $past(!i_rst_b) |-> {o_pll_range_bit3, o_pll_range_bit2, o_pll_range_bit1} == 3'h2)
        else $error("PLL range not 120 to 180 MHz band after reset");
    a_irq_rest_low: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE5]
        $past(!i_rst_b) |-> o_ext_irq == 5'h00)
        else $error("interrupt lines not low after reset");
    a_strap_driven: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE6]
        !o_proc_reset_n ##1 !o_proc_reset_n |->
            o_host_address_strap_pins_oe == 13'h1fff &&
            o_host_address_strap_pins == $past(strap_mux))
        else $error("straps not driven during processor reset");
    a_source_select: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE12]
        src_host_s |=> o_host_address_strap_pins == $past(host_s))
        else $error("host source selected but switch levels routed");
    a_latch_capture: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE18]
        $rose(o_proc_reset_n) |=> latched_ff == $past(o_host_address_strap_pins))
        else $error("strap latch missed reset release");
    a_latch_holds: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE13]
        o_proc_reset_n && proc_rst_n_d_ff |=> $stable(latched_ff) || !o_proc_reset_n)
        else $error("strap latch changed outside reset");
    a_one_enable: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE14]
        $onehot0({o_rom_enable_n, o_async_sram_enable_n, o_burst_sram_enable_n} ^ 3'h7))
        else $error("more than one memory enabled");
    a_idle_all_high: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE19]
        s0_n_s && s1_n_s && s2_n_s |=>
            {o_rom_enable_n, o_async_sram_enable_n, o_burst_sram_enable_n} == 3'h7)
        else $error("memory enabled with no space selected");
    a_rom_space1: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE15]
        o_proc_reset_n && s0_n_s && !s1_n_s |=> !o_rom_enable_n || !o_proc_reset_n)
        else $error("space 1 access did not enable ROM");
    a_burst_space0: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE16]
        o_proc_reset_n && !s0_n_s && space0_memory_type == 2'h2 |=>
            !o_burst_sram_enable_n || !o_proc_reset_n)
        else $error("space 0 burst type did not enable burst SRAM");
    a_bus_answer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus access not answered after one wait state");

    c_space0_burst: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        !o_burst_sram_enable_n);
    c_space2_async: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        !s2_n_s && s0_n_s && s1_n_s ##1 !o_async_sram_enable_n);
    c_host_source: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_proc_reset_n) && src_host_s);
endmodule

/* File: bsms_far_model.sv */
// Model of the processor memory port and the host on the strap connector
module bsms_far_model import bsms_pkg::*; (
    // Clock
    input wire logic i_clk,
    // Requests from the bench
    input wire logic [2:0] i_sel_req,
    input wire bsms_pkg::bsms_strap_t i_host_levels,
    // Strap pin drive from the block
    input wire bsms_pkg::bsms_strap_t i_pins,
    input wire bsms_pkg::bsms_strap_t i_pins_oe,
    // Towards the block
    output logic o_space0_select_n,
    output logic o_space1_select_n,
    output logic o_space2_select_n,
    output bsms_pkg::bsms_strap_t o_host_strap_levels,
    output bsms_pkg::bsms_strap_t o_pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    bsms_strap_t last_ff;
    initial begin
        o_space0_select_n = 1'b1;
        o_space1_select_n = 1'b1;
        o_space2_select_n = 1'b1;
        o_host_strap_levels = 13'h0000;
        last_ff = 13'h0000;
    end
    // Everything changes just after the edge, as the real port does
    always @(posedge i_clk) begin
        o_space0_select_n <= ~i_sel_req[0];
        o_space1_select_n <= ~i_sel_req[1];
        o_space2_select_n <= ~i_sel_req[2];
        o_host_strap_levels <= i_host_levels;
        last_ff <= o_pin_level;
    end
    // Undriven pins float; never show a stale copy of the last level
    assign o_pin_level = (i_pins & i_pins_oe) | (~last_ff & ~i_pins_oe);
endmodule

/* File: tb_top.sv */
// Self-checking bench for the boot strap and memory select block
module tb_top import bsms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 20;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic supply_ok = 1'b1;
    logic button_n = 1'b1;
    logic src = 1'b0;
    bsms_strap_t sw = 13'h0000;
    bsms_strap_t host = 13'h0000;
    logic [2:0] sel_req = 3'h0;
    logic [3:0] avs_addr = 4'h0;
    logic avs_rd = 1'b0;
    logic avs_wr = 1'b0;
    logic [31:0] avs_wd = 32'h0;
    logic [3:0] avs_be = 4'hf;
    logic proc_rst_n, mb0, mb1, rb1, rb2, rb3, en_b, en_a, en_r, wreq;
    logic s0_n, s1_n, s2_n;
    logic [4:0] irq;
    logic [31:0] rdata;
    bsms_strap_t pins, pins_oe, pin_lvl, host_lvl;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    always #4 i_clk = ~i_clk;

    bsms_top #(.RST_HOLD_CYCLES(HOLD)) dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_supply_ok(supply_ok),
        .i_reset_button_n(button_n), .o_proc_reset_n(proc_rst_n),
        .i_config_source_select(src), .i_switch_straps(sw),
        .i_host_strap_levels(host_lvl), .i_host_address_strap_pins(pin_lvl),
        .o_host_address_strap_pins(pins), .o_host_address_strap_pins_oe(pins_oe),
        .o_pll_multiplier_bit0(mb0), .o_pll_multiplier_bit1(mb1),
        .o_pll_range_bit1(rb1), .o_pll_range_bit2(rb2), .o_pll_range_bit3(rb3),
        .o_ext_irq(irq), .i_space0_select_n(s0_n), .i_space1_select_n(s1_n),
        .i_space2_select_n(s2_n), .o_burst_sram_enable_n(en_b),
        .o_async_sram_enable_n(en_a), .o_rom_enable_n(en_r),
        .i_avs_address(avs_addr), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
        .i_avs_writedata(avs_wd), .i_avs_byteenable(avs_be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq)
    );

    bsms_far_model far (
        .i_clk(i_clk), .i_sel_req(sel_req), .i_host_levels(host),
        .i_pins(pins), .i_pins_oe(pins_oe), .o_space0_select_n(s0_n),
        .o_space1_select_n(s1_n), .o_space2_select_n(s2_n),
        .o_host_strap_levels(host_lvl), .o_pin_level(pin_lvl)
    );

    task automatic end_sim;
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon-MM transfer; the request stands until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        @(posedge i_clk);
        avs_addr <= a;
        avs_wd <= wd;
        avs_be <= be;
        avs_wr <= wr;
        avs_rd <= ~wr;
        @(posedge i_clk);
        while (wreq !== 1'b0) @(posedge i_clk);
        rd = rdata;
        avs_wr <= 1'b0;
        avs_rd <= 1'b0;
        // Let a write settle before callers look at the outputs
        @(posedge i_clk);
    endtask

    task automatic wait_rel(output int n);
        n = 0;
        while (proc_rst_n !== 1'b1 && n < 200) begin
            @(posedge i_clk);
            n++;
        end
    endtask

    // Active-low {rom, async, burst} for a held type code
    function automatic logic [2:0] ten(input logic [1:0] t);
        return (t == 2'h3) ? 3'b101 : (t == 2'h2) ? 3'b110 : 3'b111;
    endfunction

    task automatic msel(input logic [2:0] req, input logic [2:0] exp);
        @(posedge i_clk);
        sel_req <= req;
        repeat (5) @(posedge i_clk);
        chk("mem_enables", {29'h0, exp}, {29'h0, en_r, en_a, en_b});
    endtask

    // Boot with straps built from c; c[1] picks host source, c[0] the reset cause
    task automatic boot(input logic [3:0] c);
        bsms_strap_t s;
        logic [31:0] d;
        int n;
        s = {3'h5, 3'(c + 4'h2), 2'(c), 2'(c ^ 4'h1), 2'(c), c[0]};
        @(posedge i_clk);
        src <= c[1];
        host <= c[1] ? s : ~s;
        sw <= c[1] ? ~s : s;
        if (c[0])
            button_n <= 1'b0;
        else
            supply_ok <= 1'b0;
        repeat (8) @(posedge i_clk);
        chk("proc_reset_n", 32'h0, {31'h0, proc_rst_n});
        chk("strap_pins", {19'h0, s}, {19'h0, pins});
        chk("strap_oe", 32'h1fff, {19'h0, pins_oe});
        bus(1'b0, 4'hc, 32'h0, 4'hf, d);
        chk("pin_readback", {18'h0, s, 1'b0}, d);
        button_n <= 1'b1;
        supply_ok <= 1'b1;
        wait_rel(n);
        chk("hold_min", 32'h1, {31'h0, n >= HOLD});
        chk("hold_max", 32'h1, {31'h0, n <= HOLD + 10});
        repeat (2) @(posedge i_clk);
        chk("strap_oe_off", 32'h0, {19'h0, pins_oe});
        bus(1'b1, 4'h4, 32'hffff_ffff, 4'hf, d);
        bus(1'b0, 4'h4, 32'h0, 4'hf, d);
        chk("sampled", {18'h0, s, c[1]}, d);
        // Straps move after release; the latch must not follow
        sw <= ~s;
        host <= ~s;
        msel(3'b001, ten(2'(c)));
        msel(3'b010, 3'b011);
        msel(3'b100, ten(2'(c ^ 4'h1)));
        msel(3'b101, ten(2'(c)));
        msel(3'b000, 3'b111);
        bus(1'b0, 4'h4, 32'h0, 4'hf, d);
        chk("sampled_held", {18'h0, s, c[1]}, d);
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        logic [31:0] d;
        int n;
        repeat (20) @(posedge i_clk);
        i_rst_b <= 1'b1;
        wait_rel(n);
        chk("hold_after_reset", 32'h1, {31'h0, n >= HOLD});
        chk("pll_mult", 32'h3, {30'h0, mb1, mb0});
        chk("pll_range", 32'h2, {29'h0, rb3, rb2, rb1});
        chk("irq_idle", 32'h0, {27'h0, irq});
        chk("enables_idle", 32'h7, {29'h0, en_r, en_a, en_b});
        bus(1'b0, 4'h0, 32'h0, 4'hf, d);
        chk("ctrl_reset", 32'h16, d);
        bus(1'b0, 4'h8, 32'h0, 4'hf, d);
        chk("mult_factor", 32'h4, {28'h0, d[11:8]});
        bus(1'b0, 4'h2, 32'h0, 4'hf, d);
        chk("unmapped", 32'h0, d);
        bus(1'b1, 4'h0, 32'h0000_0554, 4'hf, d);
        chk("irq_rise", 32'h15, {27'h0, irq});
        chk("pll_mult_x2", 32'h2, {30'h0, mb1, mb0});
        bus(1'b0, 4'h8, 32'h0, 4'hf, d);
        chk("mult_factor_x2", 32'h2, {28'h0, d[11:8]});
        bus(1'b1, 4'h0, 32'hffff_ffff, 4'h2, d);
        chk("irq_lane1", 32'h1d, {27'h0, irq});
        bus(1'b1, 4'h0, 32'h0000_0016, 4'hf, d);
        chk("irq_rest", 32'h0, {27'h0, irq});
        // Software reset: one write gives a full-length processor reset
        bus(1'b1, 4'h0, 32'h0000_0017, 4'hf, d);
        @(posedge i_clk);
        chk("soft_reset", 32'h0, {31'h0, proc_rst_n});
        wait_rel(n);
        chk("soft_hold", 32'h1, {31'h0, n >= HOLD});
        bus(1'b0, 4'h0, 32'h0, 4'hf, d);
        chk("ctrl_after_soft", 32'h16, d);
        for (int c = 0; c < 4; c++)
            boot(4'(c));
        end_sim();
    end
endmodule
